// ### rtl/fhc_ctrl.sv
// flash host controller: apb registers, command sequences, per-bank mode tracking
// Behaviour
// - only valid sequences in order; reset restores read-array
// - host resets bank on timeout_flag_bit or when in autoselect
// - two unlocks plus bank command enter autoselect, many reads allowed
// - autoselect only from read or esr, not while device busy
// - protection reads need bank and sector_select_address; reset exits to esr
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
`include "fhc_defines.svh"
module fhc_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output fhc_pkg::fhc_addr_t flash_addr,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  input wire fhc_pkg::fhc_word_t flash_dq_in,
  output fhc_pkg::fhc_word_t flash_dq_out,
  output logic flash_dq_oe,
  input wire logic flash_ready
);
  import fhc_pkg::*;

  // ********************
  // helpers
  // ********************
  function automatic fhc_addr_t phys(input fhc_addr_t w, input logic byte_mode);
    phys = byte_mode ? {w[20:0], 1'b0} : w;
  endfunction

  // expected query word for a word address
  function automatic fhc_word_t exp_query(input logic [7:0] a);
    case (a)
      8'h40: exp_query = 16'h0050;
      8'h41: exp_query = 16'h0052;
      8'h42: exp_query = 16'h0049;
      8'h43: exp_query = 16'h0031;
      8'h44: exp_query = 16'h0033;
      8'h45: exp_query = 16'h0000;
      8'h46: exp_query = 16'h0002;
      8'h47: exp_query = 16'h0001;
      8'h48: exp_query = 16'h0001;
      8'h49: exp_query = 16'h0004;
      8'h4A: exp_query = 16'h0077;
      8'h4B: exp_query = 16'h0000;
      8'h4C: exp_query = 16'h0000;
      8'h4D: exp_query = 16'h0085;
      8'h4E: exp_query = 16'h0095;
      8'h4F: exp_query = 16'h0001;
      8'h50: exp_query = 16'h0001;
      8'h57: exp_query = 16'h0004;
      8'h58: exp_query = 16'h0017;
      8'h59: exp_query = 16'h0030;
      8'h5A: exp_query = 16'h0030;
      8'h5B: exp_query = 16'h0017;
      default: exp_query = 16'h0000;
    endcase
  endfunction

  // ********************
  // registers
  // ********************
  fhc_state_e state;
  logic [3:0] cur_cmd;
  logic [1:0] cur_bank;
  logic [4:0] step;
  fhc_addr_t addr_reg;
  fhc_word_t wdata_reg;
  fhc_word_t rdata_reg;
  logic [3:0] susp;
  logic byte_mode;
  logic [4:0] qidx;
  logic err;
  logic timeout_seen;
  logic qmismatch;
  logic qvalid;
  fhc_mode_e bank_mode [0:3];

  logic wr_en;
  logic start_req;
  logic cyc_done;
  fhc_word_t cyc_rdata;
  fhc_word_t qmem_rdata;
  logic step_wr;
  logic is_last;
  fhc_addr_t step_addr;
  fhc_word_t step_data;
  logic [7:0] q_word;
  logic timeout_hit;
  logic asel_ok;

  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;
  assign start_req = wr_en && (paddr == `FHC_OFF_CTRL) && (state == S_IDLE);
  assign q_word = `FHC_Q_FIRST + {3'b000, step} - 8'h01;
  assign timeout_hit = state == S_WAIT && cyc_done && cur_cmd == `FHC_CMD_READ
    && !flash_ready && cyc_rdata[`FHC_TIMEOUT_BIT];
  // autoselect is refused while any bank is busy or the bank is already in it
  assign asel_ok = flash_ready && bank_mode[pwdata[5:4]] != FHC_MODE_ASEL;

  // ********************
  // step table of each command sequence
  // ********************
  always_comb begin
    step_wr = 1'b1;
    is_last = 1'b1;
    step_addr = addr_reg;
    step_data = wdata_reg;
    case (cur_cmd)
      `FHC_CMD_RESET: begin
        step_data = `FHC_FL_RESET;
      end
      `FHC_CMD_ASEL: begin
        is_last = step == 5'h02;
        case (step)
          5'h00: begin
            step_addr = `FHC_AD_UNLOCK1;
            step_data = `FHC_FL_UNLOCK1;
          end
          5'h01: begin
            step_addr = `FHC_AD_UNLOCK2;
            step_data = `FHC_FL_UNLOCK2;
          end
          default: begin
            step_addr = {cur_bank, 20'h0_0555};
            step_data = `FHC_FL_ASEL;
          end
        endcase
      end
      `FHC_CMD_QUERY: begin
        is_last = step == `FHC_Q_STEPS - 5'h01;
        if (step == 5'h00) begin
          step_addr = `FHC_AD_QUERY;
          step_data = `FHC_FL_QUERY;
        end else if (is_last) begin
          step_data = `FHC_FL_RESET;
        end else begin
          step_wr = 1'b0;
          step_addr = {14'h0000, q_word};
        end
      end
      `FHC_CMD_READ: begin
        step_wr = 1'b0;
      end
      default: begin
      end
    endcase
  end

  // ********************
  // sequence engine
  // ********************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      cur_cmd <= 4'h0;
      cur_bank <= 2'h0;
      step <= 5'h00;
    end else begin
      case (state)
        S_IDLE: begin
          if (start_req) begin
            cur_cmd <= pwdata[3:0];
            cur_bank <= pwdata[5:4];
            step <= 5'h00;
            if (pwdata[3:0] == `FHC_CMD_RESET || pwdata[3:0] == `FHC_CMD_QUERY
                || pwdata[3:0] == `FHC_CMD_READ || pwdata[3:0] == `FHC_CMD_WRITE
                || (pwdata[3:0] == `FHC_CMD_ASEL && asel_ok)) begin
              state <= S_ISSUE;
            end
          end
        end
        S_ISSUE: state <= S_WAIT;
        S_WAIT: begin
          if (cyc_done) begin
            if (timeout_hit) begin
              cur_cmd <= `FHC_CMD_RESET;
              step <= 5'h00;
              state <= S_ISSUE;
            end else if (is_last) begin
              state <= S_IDLE;
            end else begin
              step <= step + 5'h01;
              state <= S_ISSUE;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ********************
  // host view of each bank's mode
  // ********************
  // after power-up every bank reads array; a reset returns autoselect banks to
  // read, or to erase-suspend-read where software marked the bank suspended
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        bank_mode[i] <= FHC_MODE_READ;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (state == S_WAIT && cyc_done && is_last) begin
          if (cur_cmd == `FHC_CMD_RESET || cur_cmd == `FHC_CMD_QUERY) begin
            bank_mode[i] <= susp[i] ? FHC_MODE_ESR : FHC_MODE_READ;
          end else if (cur_cmd == `FHC_CMD_ASEL && cur_bank == 2'(i)) begin
            bank_mode[i] <= FHC_MODE_ASEL;
          end
        end else if (bank_mode[i] != FHC_MODE_ASEL) begin
          bank_mode[i] <= susp[i] ? FHC_MODE_ESR : FHC_MODE_READ;
        end
      end
    end
  end

  // ********************
  // software registers
  // ********************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg <= 22'h00_0000;
      wdata_reg <= 16'h0000;
      susp <= 4'h0;
      byte_mode <= 1'b0;
      qidx <= 5'h00;
    end else if (wr_en) begin
      case (paddr)
        `FHC_OFF_ADDR: addr_reg <= pwdata[21:0];
        `FHC_OFF_WDATA: wdata_reg <= pwdata[15:0];
        `FHC_OFF_CFG: begin
          susp <= pwdata[3:0];
          byte_mode <= pwdata[`FHC_CFG_BYTE_BIT];
        end
        `FHC_OFF_QIDX: qidx <= pwdata[4:0];
        default: begin
        end
      endcase
    end
  end

  // ********************
  // status and read data
  // ********************
  // an error or event landing in the start cycle wins over the start's clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err <= 1'b0;
      timeout_seen <= 1'b0;
      qmismatch <= 1'b0;
      qvalid <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      if (start_req && pwdata[3:0] == `FHC_CMD_ASEL && !asel_ok) begin
        err <= 1'b1;
      end else if (start_req) begin
        err <= 1'b0;
      end
      if (timeout_hit) begin
        timeout_seen <= 1'b1;
      end else if (start_req) begin
        timeout_seen <= 1'b0;
      end
      if (state == S_WAIT && cyc_done && !step_wr && cur_cmd == `FHC_CMD_QUERY
          && cyc_rdata != exp_query(q_word)) begin
        qmismatch <= 1'b1;
      end else if (start_req && pwdata[3:0] == `FHC_CMD_QUERY) begin
        qmismatch <= 1'b0;
        qvalid <= 1'b0;
      end
      if (state == S_WAIT && cyc_done && is_last && cur_cmd == `FHC_CMD_QUERY) begin
        qvalid <= 1'b1;
      end
      if (state == S_WAIT && cyc_done && !step_wr) begin
        rdata_reg <= cyc_rdata;
      end
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    case (paddr)
      `FHC_OFF_CTRL: prdata = {26'h000_0000, cur_bank, cur_cmd};
      `FHC_OFF_ADDR: prdata = {10'h000, addr_reg};
      `FHC_OFF_WDATA: prdata = {16'h0000, wdata_reg};
      `FHC_OFF_STATUS: prdata = {16'h0000, bank_mode[3], bank_mode[2], bank_mode[1],
        bank_mode[0], 3'h0, qvalid, qmismatch, timeout_seen, err, state != S_IDLE};
      `FHC_OFF_RDATA: prdata = {16'h0000, rdata_reg};
      `FHC_OFF_CFG: prdata = {23'h00_0000, byte_mode, 4'h0, susp};
      `FHC_OFF_QIDX: prdata = {27'h000_0000, qidx};
      `FHC_OFF_QDATA: prdata = {16'h0000, qmem_rdata};
      default: pslverr = psel && penable;
    endcase
  end

  // ********************
  // leaves
  // ********************
  fhc_pin_cycle u_cyc (
    .pclk(pclk),
    .presetn(presetn),
    .start(state == S_ISSUE),
    .wr(step_wr),
    .addr(phys(step_addr, byte_mode)),
    .wdata(step_data),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .flash_addr(flash_addr),
    .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n),
    .flash_dq_in(flash_dq_in),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe)
  );

  fhc_qmem u_qmem (
    .pclk(pclk),
    .we(state == S_WAIT && cyc_done && !step_wr && cur_cmd == `FHC_CMD_QUERY),
    .waddr(step - 5'h01),
    .wdata(cyc_rdata),
    .raddr(qidx),
    .rdata(qmem_rdata)
  );

  // ********************
  // checks
  // ********************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic seq_end;
  assign seq_end = state == S_WAIT && cyc_done && is_last && !timeout_hit;

  a_reset_exits_asel: assert property (seq_end && cur_cmd == `FHC_CMD_RESET
    |=> bank_mode[0] != FHC_MODE_ASEL && bank_mode[1] != FHC_MODE_ASEL
    && bank_mode[2] != FHC_MODE_ASEL && bank_mode[3] != FHC_MODE_ASEL)
    else $error("bank left in autoselect after reset");
  a_asel_enters: assert property (seq_end && cur_cmd == `FHC_CMD_ASEL
    |=> bank_mode[$past(cur_bank)] == FHC_MODE_ASEL)
    else $error("bank not in autoselect after entry sequence");
  a_asel_refused: assert property (start_req && pwdata[3:0] == `FHC_CMD_ASEL
    && !flash_ready |=> state == S_IDLE && err)
    else $error("autoselect issued while device busy");
  a_esr_return: assert property (seq_end && cur_cmd == `FHC_CMD_RESET && susp[2]
    && !(wr_en && paddr == `FHC_OFF_CFG) |=> bank_mode[2] == FHC_MODE_ESR)
    else $error("suspended bank did not return to erase-suspend-read");
  a_timeout_reset: assert property (timeout_hit
    |-> ##[2:12] (!flash_we_n && flash_dq_out == `FHC_FL_RESET))
    else $error("no reset written after timeout flag");
  a_query_window: assert property (state == S_ISSUE && cur_cmd == `FHC_CMD_QUERY
    && !step_wr |-> q_word >= `FHC_Q_FIRST && q_word <= `FHC_Q_LAST)
    else $error("query read outside extended table");
  a_query_exit: assert property (state == S_ISSUE && cur_cmd == `FHC_CMD_QUERY
    && is_last |-> step_wr && step_data == `FHC_FL_RESET)
    else $error("query mode not left with reset");
  c_asel: cover property (seq_end && cur_cmd == `FHC_CMD_ASEL);
  c_query: cover property (seq_end && cur_cmd == `FHC_CMD_QUERY && !qmismatch);
  c_timeout: cover property (timeout_hit);
endmodule

// ### rtl/fhc_pin_cycle.sv
// one asynchronous flash bus cycle, read or write, on the chip pins
`timescale 1ns/100ps
`include "fhc_defines.svh"
module fhc_pin_cycle (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic wr,
  input wire fhc_pkg::fhc_addr_t addr,
  input wire fhc_pkg::fhc_word_t wdata,
  output logic done,
  output fhc_pkg::fhc_word_t rdata,
  output fhc_pkg::fhc_addr_t flash_addr,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  input wire fhc_pkg::fhc_word_t flash_dq_in,
  output fhc_pkg::fhc_word_t flash_dq_out,
  output logic flash_dq_oe
);
  import fhc_pkg::*;
  fhc_cyc_e state;
  logic is_wr;
  logic [3:0] cnt;

  // chip select falls first so the write strobe falls later (address taken there)
  // and rises first (data taken there); data is held until chip select rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= C_IDLE;
      is_wr <= 1'b0;
      cnt <= 4'h0;
      done <= 1'b0;
      rdata <= 16'h0000;
      flash_addr <= 22'h00_0000;
      flash_dq_out <= 16'h0000;
      flash_dq_oe <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
    end else begin
      done <= 1'b0;
      case (state)
        C_IDLE: begin
          if (start) begin
            is_wr <= wr;
            flash_addr <= addr;
            flash_dq_out <= wdata;
            flash_dq_oe <= wr;
            flash_ce_n <= 1'b0;
            state <= C_SETUP;
          end
        end
        C_SETUP: begin
          flash_we_n <= !is_wr;
          flash_oe_n <= is_wr;
          cnt <= is_wr ? 4'(`FHC_TWP_CYC) : 4'(`FHC_TACC_CYC);
          state <= C_PULSE;
        end
        C_PULSE: begin
          if (cnt == 4'h1) begin
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            if (!is_wr) begin
              rdata <= flash_dq_in;
            end
            state <= C_HOLD;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        C_HOLD: begin
          flash_ce_n <= 1'b1;
          flash_dq_oe <= 1'b0;
          done <= 1'b1;
          state <= C_IDLE;
        end
        default: state <= C_IDLE;
      endcase
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_we_inside_ce: assert property (!flash_we_n |-> !flash_ce_n)
    else $error("write strobe low outside chip select");
  a_data_over_rise: assert property ($rose(flash_we_n) |-> flash_dq_oe && !flash_ce_n)
    else $error("write data not held across write strobe rise");
  a_addr_stable: assert property (!flash_ce_n && $past(!flash_ce_n) |-> $stable(flash_addr))
    else $error("address moved during a bus cycle");
endmodule

// ### rtl/fhc_qmem.sv
// small word store for the captured query table
`timescale 1ns/100ps
module fhc_qmem (
  input wire logic pclk,
  input wire logic we,
  input wire logic [4:0] waddr,
  input wire fhc_pkg::fhc_word_t wdata,
  input wire logic [4:0] raddr,
  output fhc_pkg::fhc_word_t rdata
);
  import fhc_pkg::*;
  fhc_word_t mem [0:31];

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // registered read keeps the bus read path short
  always_ff @(posedge pclk) begin
    rdata <= mem[raddr];
  end
endmodule

// ### shared/fhc_defines.svh
// constants for the flash host controller: offsets, codes, timing, query table
`ifndef FHC_DEFINES_SVH
`define FHC_DEFINES_SVH

// ********************
// register offsets
// ********************
`define FHC_OFF_CTRL 8'h00
`define FHC_OFF_ADDR 8'h04
`define FHC_OFF_WDATA 8'h08
`define FHC_OFF_STATUS 8'h0C
`define FHC_OFF_RDATA 8'h10
`define FHC_OFF_CFG 8'h14
`define FHC_OFF_QIDX 8'h18
`define FHC_OFF_QDATA 8'h1C

// ********************
// controller commands (ctrl[3:0]), bank in ctrl[5:4]
// ********************
`define FHC_CMD_RESET 4'h1
`define FHC_CMD_ASEL 4'h2
`define FHC_CMD_QUERY 4'h3
`define FHC_CMD_READ 4'h4
`define FHC_CMD_WRITE 4'h5
`define FHC_CFG_BYTE_BIT 8

// ********************
// flash bus command words and addresses
// ********************
`define FHC_FL_RESET 16'h00F0
`define FHC_FL_UNLOCK1 16'h00AA
`define FHC_FL_UNLOCK2 16'h0055
`define FHC_FL_ASEL 16'h0090
`define FHC_FL_QUERY 16'h0098
`define FHC_AD_UNLOCK1 22'h00_0555
`define FHC_AD_UNLOCK2 22'h00_02AA
`define FHC_AD_QUERY 22'h00_0055
`define FHC_Q_FIRST 8'h40
`define FHC_Q_LAST 8'h5B
`define FHC_Q_STEPS 5'h1E
`define FHC_TIMEOUT_BIT 5

// ********************
// timing
// ********************
`define FHC_CLK_NS 40
`define FHC_TWP_NS 35
`define FHC_TACC_NS 90
`define FHC_TWP_CYC ((`FHC_TWP_NS + `FHC_CLK_NS - 1) / `FHC_CLK_NS)
`define FHC_TACC_CYC ((`FHC_TACC_NS + `FHC_CLK_NS - 1) / `FHC_CLK_NS)

`endif

// ### shared/fhc_pkg.sv
// types shared by the flash host controller modules
package fhc_pkg;
  typedef enum logic [1:0] {FHC_MODE_READ, FHC_MODE_ESR, FHC_MODE_ASEL} fhc_mode_e;
  typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} fhc_state_e;
  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_PULSE, C_HOLD} fhc_cyc_e;
  typedef logic [21:0] fhc_addr_t;
  typedef logic [15:0] fhc_word_t;
endpackage

// ### test/fhc_flash_model.sv
// behavioural model of the parallel flash device at the controller's pins
`timescale 1ns/100ps
module fhc_flash_model #(
  parameter logic [15:0] ASEL_CODE = 16'h00C3 // arbitrary value
) (
  input wire fhc_pkg::fhc_addr_t flash_addr,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire fhc_pkg::fhc_word_t dq_wire,
  input wire logic byte_mode,
  input wire logic [3:0] susp,
  input wire logic busy,
  input wire logic tmo,
  output fhc_pkg::fhc_word_t dq_drv,
  output logic flash_ready
);
  import fhc_pkg::*;
  // ********************
  // query table and mode state
  // ********************
  localparam fhc_word_t QTAB [28] = '{
    16'h0050, 16'h0052, 16'h0049, 16'h0031, 16'h0033, 16'h0000,
    16'h0002, 16'h0001, 16'h0001, 16'h0004, 16'h0077, 16'h0000,
    16'h0000, 16'h0085, 16'h0095, 16'h0001, 16'h0001, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0004,
    16'h0017, 16'h0030, 16'h0030, 16'h0017};
  fhc_mode_e mode [4] = '{FHC_MODE_READ, FHC_MODE_READ, FHC_MODE_READ, FHC_MODE_READ};
  logic qmode = 1'b0;
  logic [1:0] step = 2'd0;
  int nresets = 0;
  fhc_addr_t lat_a;
  fhc_addr_t waddr;
  fhc_word_t held = 16'h0000;
  fhc_word_t rd_val;
  logic wr_n;
  logic rd_en;

  assign wr_n = flash_we_n | flash_ce_n;
  assign rd_en = !flash_ce_n && !flash_oe_n;
  assign waddr = byte_mode ? (flash_addr >> 1) : flash_addr;
  assign flash_ready = !busy;

  always_comb begin
    if (busy) begin
      rd_val = {10'h000, tmo, 5'h00};
    end else if (qmode) begin
      if (waddr >= 22'h00_0040 && waddr <= 22'h00_005B) begin
        rd_val = QTAB[5'(waddr - 22'h00_0040)];
      end else begin
        rd_val = 16'h0000;
      end
    end else if (mode[waddr[21:20]] == FHC_MODE_ASEL) begin
      rd_val = ASEL_CODE;
    end else begin
      rd_val = waddr[15:0] ^ 16'h5A5A;
    end
  end

  // a released bus shows the inverse of the last word so stale data never matches
  always @(negedge rd_en) held <= rd_val;
  assign dq_drv = rd_en ? rd_val : ~held;

  always @(negedge wr_n) lat_a <= waddr;

  always @(posedge wr_n) begin
    if (dq_wire == 16'h00F0) begin
      if (!busy || tmo) begin
        for (int b = 0; b < 4; b++) begin
          mode[b] <= susp[b] ? FHC_MODE_ESR : FHC_MODE_READ;
        end
        qmode <= 1'b0;
        step <= 2'd0;
        nresets <= nresets + 1;
      end
    end else if (busy) begin
      step <= 2'd0;
    end else if (step == 2'd0 && lat_a[11:0] == 12'h555 && dq_wire == 16'h00AA) begin
      step <= 2'd1;
    end else if (step == 2'd1 && lat_a[11:0] == 12'h2AA && dq_wire == 16'h0055) begin
      step <= 2'd2;
    end else if (step == 2'd2 && lat_a[19:0] == 20'h0_0555 && dq_wire == 16'h0090) begin
      mode[lat_a[21:20]] <= FHC_MODE_ASEL;
      step <= 2'd0;
    end else if (lat_a[7:0] == 8'h55 && dq_wire == 16'h0098) begin
      qmode <= 1'b1;
    end else begin
      step <= 2'd0;
    end
  end
endmodule

// ### test/tb_fhc_ctrl.sv
// self-checking bench for the flash host controller
`timescale 1ns/100ps
`include "fhc_defines.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_fhc_ctrl;
  import fhc_pkg::*;
  localparam logic [15:0] ASEL_CODE = 16'h00C3; // arbitrary value
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  fhc_addr_t flash_addr;
  logic flash_ce_n;
  logic flash_we_n;
  logic flash_oe_n;
  fhc_word_t flash_dq_out;
  fhc_word_t dq_drv;
  fhc_word_t dq_wire;
  logic flash_dq_oe;
  logic flash_ready;
  logic byte_mode = 1'b0;
  logic [3:0] susp = 4'h0;
  logic busy = 1'b0;
  logic tmo = 1'b0;
  logic [31:0] rd;
  logic err;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int n0;

  always #20 pclk = ~pclk;
  assign dq_wire = flash_dq_oe ? flash_dq_out : dq_drv;

  fhc_ctrl dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flash_addr(flash_addr), .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n), .flash_dq_in(dq_wire),
    .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_ready(flash_ready));

  fhc_flash_model #(.ASEL_CODE(ASEL_CODE)) flash_u (.flash_addr(flash_addr),
    .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
    .dq_wire(dq_wire), .byte_mode(byte_mode), .susp(susp), .busy(busy), .tmo(tmo),
    .dq_drv(dq_drv), .flash_ready(flash_ready));

  // ********************
  // bus tasks
  // ********************
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // leaves the final status word in rd
  task automatic cmd(input logic [3:0] c, input logic [1:0] b);
    apb(1'b1, `FHC_OFF_CTRL, {26'h000_0000, b, c});
    rd = 32'h0000_0001;
    for (int i = 0; i < 300 && rd[0] !== 1'b0; i++) apb(1'b0, `FHC_OFF_STATUS, 32'h0000_0000);
    // a command that never finishes counts as a mismatch
    if (rd[0] !== 1'b0) begin
      num_errors++;
    end
  endtask

  // a hang counts as a mismatch
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `FHC_OFF_STATUS, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    apb(1'b0, 8'h40, 32'h0000_0000);
    `CHK(err, 1'b1)
    $display("test reset done");
    cmd(`FHC_CMD_QUERY, 2'd0);
    `CHK(rd[4:3], 2'b10)
    for (int i = 0; i < 28; i++) begin
      apb(1'b1, `FHC_OFF_QIDX, 32'(i));
      apb(1'b0, `FHC_OFF_QDATA, 32'h0000_0000);
      `CHK(rd, {16'h0000, flash_u.QTAB[i]})
    end
    apb(1'b1, `FHC_OFF_CFG, 32'h0000_0100);
    byte_mode <= 1'b1;
    cmd(`FHC_CMD_QUERY, 2'd0);
    `CHK(rd[4:3], 2'b10)
    `CHK(flash_u.qmode, 1'b0)
    $display("test query done");
    apb(1'b1, `FHC_OFF_CFG, 32'h0000_0004);
    byte_mode <= 1'b0;
    susp <= 4'h4;
    cmd(`FHC_CMD_ASEL, 2'd2);
    `CHK(rd[13:12], 2'b10)
    `CHK(flash_u.mode[2], FHC_MODE_ASEL)
    apb(1'b1, `FHC_OFF_ADDR, 32'h0020_0000);
    repeat (2) begin
      cmd(`FHC_CMD_READ, 2'd2);
      apb(1'b0, `FHC_OFF_RDATA, 32'h0000_0000);
      `CHK(rd, {16'h0000, ASEL_CODE})
    end
    cmd(`FHC_CMD_ASEL, 2'd2);
    `CHK(rd[1], 1'b1)
    cmd(`FHC_CMD_RESET, 2'd0);
    `CHK(rd[13:12], 2'b01)
    `CHK(flash_u.mode[2], FHC_MODE_ESR)
    apb(1'b1, `FHC_OFF_ADDR, 32'h0020_0123);
    cmd(`FHC_CMD_READ, 2'd2);
    apb(1'b0, `FHC_OFF_RDATA, 32'h0000_0000);
    `CHK(rd, {16'h0000, 16'h0123 ^ 16'h5A5A})
    $display("test autoselect done");
    apb(1'b1, `FHC_OFF_ADDR, 32'h0000_0555);
    apb(1'b1, `FHC_OFF_WDATA, 32'h0000_00AA);
    cmd(`FHC_CMD_WRITE, 2'd0);
    `CHK(flash_u.step, 2'd1)
    `CHK(flash_u.lat_a, 22'h00_0555)
    cmd(`FHC_CMD_RESET, 2'd0);
    `CHK(flash_u.step, 2'd0)
    `CHK(rd[9:8], 2'b00)
    $display("test abort done");
    busy <= 1'b1;
    tmo <= 1'b1;
    n0 = flash_u.nresets;
    apb(1'b1, `FHC_OFF_ADDR, 32'h0000_0010);
    cmd(`FHC_CMD_READ, 2'd0);
    `CHK(rd[2], 1'b1)
    `CHK(flash_u.nresets, n0 + 1)
    tmo <= 1'b0;
    cmd(`FHC_CMD_ASEL, 2'd1);
    `CHK(rd[1], 1'b1)
    `CHK(rd[11:10], 2'b00)
    n0 = flash_u.nresets;
    cmd(`FHC_CMD_RESET, 2'd0);
    `CHK(flash_u.nresets, n0)
    busy <= 1'b0;
    $display("test timeout done");
    wrap_up();
  end
endmodule
